// ===== include/sfs_pkg.sv
// constants shared by the switch fault supervisor
package sfs_pkg;
   // clock rate
   localparam int CLK_MHZ = 10;

   // apb map, byte addresses
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTRL_OFFSET = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   localparam logic [11:0] LIVE_OFFSET = 12'h008;

   // control register fields
   localparam int CTRL_W = 10;
   localparam int CTRL_OUT_CMD = 0;
   localparam int CTRL_OVERVOLTAGE_DISABLE = 1;
   localparam int CTRL_UNDERVOLTAGE_DISABLE = 2;
   localparam int CTRL_OPEN_LOAD_DISABLE = 3;
   localparam int CTRL_LOW_SEL = 4;
   localparam int CTRL_HIGH_SEL = 7;
   localparam int CTRL_BLANK_SEL = 8;
   localparam logic [9:0] CTRL_RESET = 10'h000;

   // status register fields, sticky, cleared by a read
   localparam int STAT_W = 6;
   localparam int STAT_OVERTEMP = 0;
   localparam int STAT_OVERVOLT = 1;
   localparam int STAT_UNDERVOLT = 2;
   localparam int STAT_OPENLOAD = 3;
   localparam int STAT_OC_LOW = 4;
   localparam int STAT_OC_HIGH = 5;
   localparam logic [5:0] STAT_RESET = 6'h00;

   // live register width
   localparam int LIVE_W = 5;

   // synchronised comparator inputs, bit positions
   localparam int SYN_W = 16;
   localparam int SYN_OT = 0;
   localparam int SYN_OV = 1;
   localparam int SYN_UV = 2;
   localparam int SYN_POR = 3;
   localparam int SYN_OL = 4;
   localparam int SYN_GATE = 5;
   localparam int SYN_LOW = 6;
   localparam int SYN_HIGH = 14;
   localparam logic [15:0] SYN_RESET = 16'h0000;

   // over-current blanking times in microseconds
   localparam int BLANK0_US = 10;
   localparam int BLANK1_US = 20;
   localparam int BLANK2_US = 40;
   localparam int BLANK3_US = 80;
   localparam logic [15:0] BLANK0_CYC = 16'(BLANK0_US * CLK_MHZ);
   localparam logic [15:0] BLANK1_CYC = 16'(BLANK1_US * CLK_MHZ);
   localparam logic [15:0] BLANK2_CYC = 16'(BLANK2_US * CLK_MHZ);
   localparam logic [15:0] BLANK3_CYC = 16'(BLANK3_US * CLK_MHZ);
   localparam logic [15:0] CNT_RESET = 16'h0000;
endpackage

// ===== design/sfs_blank_timer.sv
// over-current blanking timer, expired stays high for as long as the run level outlasts the limit
`timescale 1ns/1ps
module sfs_blank_timer (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // control
   input wire logic run,
   input wire logic [15:0] limit,
   // result
   output logic expired
);
   import sfs_pkg::*;

   logic [15:0] count_q;

   // counter restarts whenever the current drops below the trip level
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= CNT_RESET;
      end else if (!run) begin
         count_q <= CNT_RESET;
      end else if (count_q != limit) begin
         count_q <= count_q + 16'h0001;
      end
   end

   // strictly longer than the limit before expiry
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         expired <= 1'b0;
      end else begin
         expired <= run && (count_q == limit);
      end
   end
endmodule

// ===== design/sfs_supervisor.sv
// fault supervisor for a high side switch, apb register slave
`timescale 1ns/1ps
//
// Function
// - fault pin goes low on any temperature, supply, open load or current fault
// - fault pin releases by itself, except over-current and latched under-voltage
// - faults stay stored and are read out and cleared by the first read after the fault is gone
// - over-temperature is detected only while the output is on
// - over-temperature turns output off until cooled, then on again, repeating
// - over-temperature sets a sticky flag cleared only by read or reset
// - over-voltage holds the output off while present, no latching
// - over-voltage sets status bit one, cleared by read or reset
// - over-voltage disable stops both action and report
// - under-voltage turns output off, pulls fault pin low, sets flag
// - recovery with output commanded off releases pin, flag stays until read
// - recovery with output commanded on keeps off until command cycles off
// - under-voltage disable hides it; output off only below the reset level
// - open load is detected and reported only while the output is off
// - open load latches once gate is off; read clears it if gone
// - eight low and two high trip levels, both selected ones watched
// - low trip outlasting the blanking time latches the output off
// - high trip latches the fault and turns the output off at once
// - after over-current latch-off output stays off until commanded off then on
module sfs_supervisor (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sfs_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog comparator pins, asynchronous
   input wire logic overTempCmp,
   input wire logic overVoltCmp,
   input wire logic underVoltCmp,
   input wire logic supplyPorCmp,
   input wire logic openLoadCmp,
   input wire logic gateOffCmp,
   input wire logic [7:0] lowTripCmp,
   input wire logic [1:0] highTripCmp,
   // switch and fault pin
   output logic outputOn,
   output logic faultFlagN
);
   import sfs_pkg::*;

   function automatic logic isAddr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      return a[ADDR_W-1:2] == off[ADDR_W-1:2];
   endfunction

   logic [SYN_W-1:0] syncA_q;
   logic [SYN_W-1:0] syncB_q;
   logic [CTRL_W-1:0] ctrl_q;
   logic [STAT_W-1:0] statFlags_q;
   logic [STAT_W-1:0] statSet;
   logic otShut_q;
   logic uvLatch_q;
   logic ocLatch_q;
   logic outputOn_d;
   logic faultAny;
   logic access;
   logic commit;
   logic statRead;
   logic mapped;
   logic [31:0] readMux;
   logic cmdOn;
   logic ovDis;
   logic uvDis;
   logic olDis;
   logic [2:0] lowSel;
   logic highSel;
   logic [1:0] blankSel;
   logic [15:0] blankLimit;
   logic otS;
   logic ovS;
   logic uvS;
   logic porS;
   logic olS;
   logic gateS;
   logic [7:0] lowVec;
   logic [1:0] highVec;
   logic lowHit;
   logic highHit;
   logic ovAct;
   logic uvAct;
   logic olAct;
   logic otEv;
   logic highEv;
   logic blankRun;
   logic blankExpired;

   // pins cross into core_clk through two flops; only syncB_q is read
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         syncA_q <= SYN_RESET;
         syncB_q <= SYN_RESET;
      end else begin
         syncA_q <= {highTripCmp, lowTripCmp, gateOffCmp, openLoadCmp, supplyPorCmp, underVoltCmp, overVoltCmp,
                     overTempCmp};
         syncB_q <= syncA_q;
      end
   end

   assign otS = syncB_q[SYN_OT];
   assign ovS = syncB_q[SYN_OV];
   assign uvS = syncB_q[SYN_UV];
   assign porS = syncB_q[SYN_POR];
   assign olS = syncB_q[SYN_OL];
   assign gateS = syncB_q[SYN_GATE];
   assign lowVec = syncB_q[SYN_LOW +: 8];
   assign highVec = syncB_q[SYN_HIGH +: 2];

   // control fields
   assign cmdOn = ctrl_q[CTRL_OUT_CMD];
   assign ovDis = ctrl_q[CTRL_OVERVOLTAGE_DISABLE];
   assign uvDis = ctrl_q[CTRL_UNDERVOLTAGE_DISABLE];
   assign olDis = ctrl_q[CTRL_OPEN_LOAD_DISABLE];
   assign lowSel = ctrl_q[CTRL_LOW_SEL +: 3];
   assign highSel = ctrl_q[CTRL_HIGH_SEL];
   assign blankSel = ctrl_q[CTRL_BLANK_SEL +: 2];

   // apb: one wait state so read data leaves a flop
   assign access = psel && penable && !pready;
   assign commit = psel && penable && pready;
   assign mapped = isAddr(paddr, CTRL_OFFSET) || isAddr(paddr, STATUS_OFFSET) || isAddr(paddr, LIVE_OFFSET);
   assign statRead = access && !pwrite && isAddr(paddr, STATUS_OFFSET);

   always_comb begin
      readMux = 32'h0000_0000;
      if (isAddr(paddr, CTRL_OFFSET)) begin
         readMux[CTRL_W-1:0] = ctrl_q;
      end else if (isAddr(paddr, STATUS_OFFSET)) begin
         readMux[STAT_W-1:0] = statFlags_q;
      end else if (isAddr(paddr, LIVE_OFFSET)) begin
         readMux[LIVE_W-1:0] = {ocLatch_q, uvLatch_q, otShut_q, faultFlagN, outputOn};
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= access;
         pslverr <= access && !mapped;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h0000_0000;
      end else if (access) begin
         prdata <= pwrite ? 32'h0000_0000 : readMux;
      end
   end

   // writes land on the edge that completes the transfer
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (commit && pwrite && isAddr(paddr, CTRL_OFFSET)) begin
         ctrl_q <= pwdata[CTRL_W-1:0];
      end
   end

   // trip level selection, both selected levels watched together
   assign lowHit = lowVec[lowSel];
   assign highHit = highVec[highSel];

   always_comb begin
      unique case (blankSel)
         2'h0: blankLimit = BLANK0_CYC;
         2'h1: blankLimit = BLANK1_CYC;
         2'h2: blankLimit = BLANK2_CYC;
         2'h3: blankLimit = BLANK3_CYC;
      endcase
   end

   assign blankRun = lowHit && outputOn && !ocLatch_q;

   sfs_blank_timer blank_timer (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .run(blankRun),
      .limit(blankLimit),
      .expired(blankExpired)
   );

   // condition decode
   assign ovAct = ovS && !ovDis;
   assign uvAct = uvS && !uvDis;
   assign olAct = olS && gateS && !olDis && !outputOn;
   assign otEv = otS && (outputOn || otShut_q);
   assign highEv = highHit && outputOn && !ocLatch_q;

   // thermal cycling; comparator carries the hysteresis
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         otShut_q <= 1'b0;
      end else if (!cmdOn || !otS) begin
         otShut_q <= 1'b0;
      end else if (outputOn) begin
         otShut_q <= 1'b1;
      end
   end

   // under-voltage latch only while commanded on
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         uvLatch_q <= 1'b0;
      end else if (!cmdOn) begin
         uvLatch_q <= 1'b0;
      end else if (uvAct) begin
         uvLatch_q <= 1'b1;
      end
   end

   // over-current latch, released only by commanding off
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ocLatch_q <= 1'b0;
      end else if (!cmdOn) begin
         ocLatch_q <= 1'b0;
      end else if (blankExpired || highEv) begin
         ocLatch_q <= 1'b1;
      end
   end

   // output gate; reset level stops it even with under-voltage hidden
   assign outputOn_d = cmdOn && !ocLatch_q && !otShut_q && !ovAct && !porS
                       && !uvAct && !uvLatch_q;

   assign faultAny = otShut_q || ovAct || uvAct || uvLatch_q || olAct || ocLatch_q;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         outputOn <= 1'b0;
         faultFlagN <= 1'b1;
      end else begin
         outputOn <= outputOn_d;
         faultFlagN <= !faultAny;
      end
   end

   // sticky flags; a new event beats the read clear
   always_comb begin
      statSet = STAT_RESET;
      statSet[STAT_OVERTEMP] = otEv;
      statSet[STAT_OVERVOLT] = ovAct;
      statSet[STAT_UNDERVOLT] = uvAct;
      statSet[STAT_OPENLOAD] = olAct;
      statSet[STAT_OC_LOW] = blankExpired;
      statSet[STAT_OC_HIGH] = highEv;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         statFlags_q <= STAT_RESET;
      end else begin
         statFlags_q <= statSet | (statFlags_q & ~{STAT_W{statRead}});
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   property p_pinLow;
      faultAny |=> !faultFlagN;
   endproperty
   a_pinLow: assert property (p_pinLow) else $error("fault pin not low on fault");

   property p_pinRelease;
      !faultAny |=> faultFlagN;
   endproperty
   a_pinRelease: assert property (p_pinRelease) else $error("fault pin not released");

   property p_readClear;
      statRead && (statSet == STAT_RESET) |=> (statFlags_q == STAT_RESET) && (prdata[STAT_W-1:0] == $past(statFlags_q));
   endproperty
   a_readClear: assert property (p_readClear) else $error("status read did not capture and clear");

   property p_setWins;
      statRead && statSet[STAT_OVERVOLT] |=> statFlags_q[STAT_OVERVOLT];
   endproperty
   a_setWins: assert property (p_setWins) else $error("event lost during read");

   property p_otOnlyOn;
      !outputOn && !otShut_q |=> !otShut_q;
   endproperty
   a_otOnlyOn: assert property (p_otOnlyOn) else $error("thermal shutdown while off");

   property p_otOff;
      otShut_q |=> !outputOn;
   endproperty
   a_otOff: assert property (p_otOff) else $error("output on during thermal shutdown");

   property p_otFlag;
      otEv |=> statFlags_q[STAT_OVERTEMP];
   endproperty
   a_otFlag: assert property (p_otFlag) else $error("overtemp flag not set");

   property p_ovOff;
      ovS && !ovDis |=> !outputOn && statFlags_q[STAT_OVERVOLT];
   endproperty
   a_ovOff: assert property (p_ovOff) else $error("over-voltage not acted on");

   property p_ovDis;
      ovDis && !uvAct && !uvLatch_q && !otShut_q && !olAct && !ocLatch_q |=> faultFlagN;
   endproperty
   a_ovDis: assert property (p_ovDis) else $error("disabled over-voltage reported");

   property p_uvOff;
      uvS && !uvDis |=> !outputOn && !faultFlagN && statFlags_q[STAT_UNDERVOLT];
   endproperty
   a_uvOff: assert property (p_uvOff) else $error("under-voltage not acted on");

   property p_uvHold;
      uvLatch_q && cmdOn |=> uvLatch_q && !outputOn;
   endproperty
   a_uvHold: assert property (p_uvHold) else $error("under-voltage latch released while on");

   property p_olOff;
      outputOn && !statFlags_q[STAT_OPENLOAD] |=> !statFlags_q[STAT_OPENLOAD];
   endproperty
   a_olOff: assert property (p_olOff) else $error("open load while on");

   property p_highTrip;
      highEv && cmdOn |=> ocLatch_q ##1 !outputOn;
   endproperty
   a_highTrip: assert property (p_highTrip) else $error("high trip did not latch off");

   property p_blank;
      blankExpired && cmdOn |=> ocLatch_q;
   endproperty
   a_blank: assert property (p_blank) else $error("blanking expiry did not latch");

   property p_ocStay;
      ocLatch_q && cmdOn |=> ocLatch_q && !outputOn;
   endproperty
   a_ocStay: assert property (p_ocStay) else $error("over-current latch released");

   c_otCycle: cover property (otShut_q ##[1:50] !otShut_q && outputOn);
   c_ocLatch: cover property (highEv ##2 !outputOn);
   c_uvLatch: cover property (uvLatch_q && !uvS && cmdOn);
   c_statRead: cover property (statRead && (statFlags_q != STAT_RESET));
endmodule

// ===== verification/sfs_host_model.sv
// apb host model driving the supervisor registers
`timescale 1ns/1ps
module sfs_host_model (
   // clock
   input wire logic core_clk,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [sfs_pkg::ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   import sfs_pkg::*;
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'hfff;
      pwdata = 32'h5a5a5a5a;
   end
   // request held until pready is seen high at an edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge core_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      @(posedge core_clk);
      while (pready !== 1'h1) @(posedge core_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // released lines show the inverse, not a stale copy
      paddr <= ~a;
      pwdata <= ~d;
   endtask
   // command off then on again, the only way out of a latch
   task automatic recycle(input logic [31:0] c);
      logic [31:0] r;
      logic e;
      xfer(1'h1, CTRL_OFFSET, c & 32'hfffffffe, r, e);
      xfer(1'h1, CTRL_OFFSET, c | 32'h1, r, e);
   endtask
endmodule

// ===== verification/tb.sv
// self-checking bench for the switch fault supervisor
`timescale 1ns/1ps
module tb;
   import sfs_pkg::*;
   typedef struct {
      logic [9:0] ctrl;
      logic [5:0] pin;
      logic [7:0] low;
      logic [1:0] high;
      logic eo;
      logic ef;
      logic [5:0] st;
   } sfs_row_t;
   // pin bits: ot ov uv por ol gate
   sfs_row_t rows [15] = '{
      '{10'h001, 6'h00, 8'h00, 2'h0, 1'h1, 1'h1, 6'h00}, '{10'h001, 6'h01, 8'h00, 2'h0, 1'h0, 1'h0, 6'h01},
      '{10'h000, 6'h01, 8'h00, 2'h0, 1'h0, 1'h1, 6'h00}, '{10'h001, 6'h02, 8'h00, 2'h0, 1'h0, 1'h0, 6'h02},
      '{10'h003, 6'h02, 8'h00, 2'h0, 1'h1, 1'h1, 6'h00}, '{10'h001, 6'h04, 8'h00, 2'h0, 1'h0, 1'h0, 6'h04},
      '{10'h005, 6'h04, 8'h00, 2'h0, 1'h1, 1'h1, 6'h00}, '{10'h005, 6'h0c, 8'h00, 2'h0, 1'h0, 1'h1, 6'h00},
      '{10'h000, 6'h30, 8'h00, 2'h0, 1'h0, 1'h0, 6'h08}, '{10'h001, 6'h30, 8'h00, 2'h0, 1'h1, 1'h1, 6'h00},
      '{10'h008, 6'h30, 8'h00, 2'h0, 1'h0, 1'h1, 6'h00}, '{10'h001, 6'h00, 8'h00, 2'h1, 1'h0, 1'h0, 6'h20},
      '{10'h081, 6'h00, 8'h00, 2'h1, 1'h1, 1'h1, 6'h00}, '{10'h001, 6'h00, 8'h01, 2'h0, 1'h0, 1'h0, 6'h10},
      '{10'h071, 6'h00, 8'h7f, 2'h0, 1'h1, 1'h1, 6'h00}};
   localparam int LIMIT = 20000;
   logic core_clk = 1'h0;
   logic reset_n;
   logic psel, penable, pwrite, pready, pslverr, outputOn, faultFlagN;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [5:0] pins;
   logic [7:0] lowTrip;
   logic [1:0] highTrip;
   int miscompares = 0;
   int totalChecks = 0;
   int cycles = 0;

   always #50 core_clk = ~core_clk;

   sfs_supervisor dut_u (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .overTempCmp(pins[0]), .overVoltCmp(pins[1]), .underVoltCmp(pins[2]), .supplyPorCmp(pins[3]),
      .openLoadCmp(pins[4]), .gateOffCmp(pins[5]), .lowTripCmp(lowTrip), .highTripCmp(highTrip),
      .outputOn(outputOn), .faultFlagN(faultFlagN));
   sfs_host_model host_u (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   task automatic close_out();
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         close_out();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic chk1(input logic got, input logic exp);
      totalChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t pin got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t word got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      host_u.xfer(1'h1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
      logic [31:0] r;
      logic e;
      host_u.xfer(1'h0, a, 32'h0, r, e);
      chk32(r, exp);
      chk1(e, expErr);
   endtask
   // drop every fault and latch, then empty the sticky flags
   task automatic clearAll();
      logic [31:0] r;
      logic e;
      pins <= 6'h00;
      lowTrip <= 8'h00;
      highTrip <= 2'h0;
      wr(CTRL_OFFSET, 32'h0);
      cyc(8);
      host_u.xfer(1'h0, STATUS_OFFSET, 32'h0, r, e);
   endtask
   task automatic runRow(input sfs_row_t r);
      clearAll();
      wr(CTRL_OFFSET, {22'h0, r.ctrl});
      cyc(8);
      pins <= r.pin;
      lowTrip <= r.low;
      highTrip <= r.high;
      // long enough for the shortest blanking time
      cyc(120);
      chk1(outputOn, r.eo);
      chk1(faultFlagN, r.ef);
      rd(STATUS_OFFSET, {26'h0, r.st}, 1'h0);
      $display("test row %h done", r.ctrl);
   endtask
   task automatic sticky(input logic [31:0] c, input logic [5:0] p, input logic [31:0] s);
      clearAll();
      wr(CTRL_OFFSET, c);
      pins <= p;
      cyc(8);
      rd(STATUS_OFFSET, s, 1'h0);
      rd(STATUS_OFFSET, s, 1'h0);
      pins <= 6'h00;
      cyc(8);
      rd(STATUS_OFFSET, s, 1'h0);
      rd(STATUS_OFFSET, 32'h0, 1'h0);
      $display("test sticky %h done", s);
   endtask

   initial begin
      sfs_row_t tr;
      int bl;
      pins = 6'h00;
      lowTrip = 8'h00;
      highTrip = 2'h0;
      reset_n = 1'h0;
      cyc(12);
      reset_n <= 1'h1;
      chk1(outputOn, 1'h0);
      chk1(faultFlagN, 1'h1);
      rd(CTRL_OFFSET, 32'h0, 1'h0);
      rd(STATUS_OFFSET, 32'h0, 1'h0);
      rd(LIVE_OFFSET, 32'h2, 1'h0);
      wr(CTRL_OFFSET, 32'hffffffff);
      wr(STATUS_OFFSET, 32'hffffffff);
      rd(12'h00c, 32'h0, 1'h1);
      rd(CTRL_OFFSET, 32'h3ff, 1'h0);
      rd(STATUS_OFFSET, 32'h0, 1'h0);
      rd(LIVE_OFFSET, 32'h3, 1'h0);
      $display("test registers done");
      foreach (rows[i]) runRow(rows[i]);
      for (int i = 0; i < 10; i++) begin
         tr = '{10'h001, 6'h00, 8'h00, 2'h0, 1'h0, 1'h0, 6'h10};
         if (i < 8) begin
            tr.ctrl[6:4] = 3'(i);
            tr.low = 8'h01 << i;
         end else begin
            tr.ctrl[7] = 1'(i - 8);
            tr.high = 2'h1 << (i - 8);
            tr.st = 6'h20;
         end
         runRow(tr);
      end
      $display("test rows done");
      clearAll();
      wr(CTRL_OFFSET, 32'h1);
      pins <= 6'h01;
      cyc(8);
      chk1(outputOn, 1'h0);
      chk1(faultFlagN, 1'h0);
      rd(LIVE_OFFSET, 32'h4, 1'h0);
      pins <= 6'h00;
      cyc(8);
      chk1(outputOn, 1'h1);
      chk1(faultFlagN, 1'h1);
      pins <= 6'h01;
      cyc(8);
      chk1(outputOn, 1'h0);
      pins <= 6'h00;
      cyc(8);
      rd(STATUS_OFFSET, 32'h1, 1'h0);
      rd(STATUS_OFFSET, 32'h0, 1'h0);
      $display("test thermal done");
      clearAll();
      wr(CTRL_OFFSET, 32'h1);
      pins <= 6'h04;
      cyc(8);
      chk1(faultFlagN, 1'h0);
      pins <= 6'h00;
      cyc(8);
      chk1(outputOn, 1'h0);
      chk1(faultFlagN, 1'h0);
      rd(LIVE_OFFSET, 32'h8, 1'h0);
      host_u.recycle(32'h1);
      cyc(8);
      chk1(outputOn, 1'h1);
      chk1(faultFlagN, 1'h1);
      rd(STATUS_OFFSET, 32'h4, 1'h0);
      wr(CTRL_OFFSET, 32'h0);
      pins <= 6'h04;
      cyc(8);
      pins <= 6'h00;
      cyc(8);
      chk1(faultFlagN, 1'h1);
      rd(STATUS_OFFSET, 32'h4, 1'h0);
      $display("test undervoltage done");
      clearAll();
      wr(CTRL_OFFSET, 32'h1);
      highTrip <= 2'h1;
      cyc(8);
      highTrip <= 2'h0;
      cyc(8);
      chk1(outputOn, 1'h0);
      chk1(faultFlagN, 1'h0);
      rd(LIVE_OFFSET, 32'h10, 1'h0);
      host_u.recycle(32'h1);
      cyc(8);
      chk1(outputOn, 1'h1);
      $display("test latch done");
      // every longer blanking choice, each against its own limit
      for (int b = 1; b < 4; b++) begin
         bl = (b == 1) ? int'(BLANK1_CYC) : (b == 2) ? int'(BLANK2_CYC) : int'(BLANK3_CYC);
         clearAll();
         wr(CTRL_OFFSET, {22'h0, 2'(b), 8'h01});
         lowTrip <= 8'h01;
         cyc(bl - 10);
         chk1(outputOn, 1'h1);
         cyc(25);
         chk1(outputOn, 1'h0);
         rd(STATUS_OFFSET, 32'h10, 1'h0);
      end
      $display("test blanking done");
      sticky(32'h1, 6'h02, 32'h2);
      sticky(32'h0, 6'h30, 32'h8);
      wr(CTRL_OFFSET, 32'h1);
      reset_n <= 1'h0;
      cyc(3);
      chk1(outputOn, 1'h0);
      chk1(faultFlagN, 1'h1);
      reset_n <= 1'h1;
      rd(CTRL_OFFSET, 32'h0, 1'h0);
      $display("test reset done");
      close_out();
   end
endmodule
